// ---- logic/lsd_defs.vh ----
// Constants of the serial command decoder of the four-digit LED driver.
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH

// ==========================================================================
// Word fields.
`define LSD_MODE_HI      15
`define LSD_MODE_LO      12
`define LSD_SEL_HI       11
`define LSD_SEL_LO       8

// ==========================================================================
// Mode codes.
`define LSD_MODE_BLANK   4'h0
`define LSD_MODE_NORMAL  4'h1
`define LSD_MODE_LOAD    4'h2
`define LSD_MODE_ALLON   4'h3
`define LSD_MODE_STBY    4'h4

// ==========================================================================
// Register selectors and the standby nibble that means data clear.
`define LSD_SEL_DUTY     4'h0
`define LSD_SEL_DECDIG   4'h1
`define LSD_SEL_DATA0    4'h2
`define LSD_SEL_DATA3    4'h5
`define LSD_STBY_CLEAR   4'h0

// ==========================================================================
// Reset values.
`define LSD_DUTY_RST     4'hf
`define LSD_DECODE_RST   4'h1
`define LSD_COUNT_RST    2'h3
`define LSD_DATA_RST     8'h00

// ==========================================================================
// Timing: clock period and length of one duty sixteenth of a digit slot.
`define LSD_CLK_NS       20
`define LSD_SUBSLOT_NS   1280

`endif

// ---- logic/lsd_pin_sync.v ----
// Two-stage synchronisers with edge detection for the serial pins.
`timescale 1ns/1ps
`default_nettype none

module lsd_pin_sync #(
  parameter WIDTH = 3
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);

  // ========================================================================
  // Synchroniser stages.
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;
  reg [WIDTH-1:0] prev;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // The first stage is only ever read by the second one.
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          meta[g]   <= 1'b0;
          stable[g] <= 1'b0;
          prev[g]   <= 1'b0;
        end else begin
          meta[g]   <= pin_i[g];
          stable[g] <= meta[g];
          prev[g]   <= stable[g];
        end
      end
      // Edges come from the second and third stages.
      assign rise_o[g] = stable[g] & ~prev[g];
      assign fall_o[g] = ~stable[g] & prev[g];
    end
  endgenerate

  assign level_o = stable;

endmodule
`default_nettype wire

// ---- logic/lsd_scan.v ----
// Digit scanner: walks enabled digits and gates each by the duty setting.
`timescale 1ns/1ps
`include "lsd_defs.vh"
`default_nettype none

module lsd_scan #(
  parameter SUBSLOT_CYCLES = `LSD_SUBSLOT_NS / `LSD_CLK_NS
) (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       run_i,
  input  wire [1:0] count_i,
  input  wire [3:0] duty_i,
  output reg  [1:0] digit_o,
  output reg        lit_o
);

  // ========================================================================
  // Divider making one enable pulse per duty sixteenth.
  reg [15:0] div;
  wire       tick = (div == SUBSLOT_CYCLES[15:0] - 16'h0001);

  always @(posedge clk_i) begin
    if (!rst_b_i || !run_i || tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  // ========================================================================
  // Phase within the slot and the digit that owns the slot.
  reg [3:0] phase;

  // Count 0..3 enables digits zero only up to zero through three.
  always @(posedge clk_i) begin
    if (!rst_b_i || !run_i) begin
      phase   <= 4'h0;
      digit_o <= 2'h0;
    end else if (tick) begin
      phase <= phase + 4'h1;
      if (phase == 4'hf) begin
        digit_o <= (digit_o >= count_i) ? 2'h0 : digit_o + 2'h1;
      end
    end
  end

  // The digit is on for duty sixteenths of its slot, so duty 0 is dark.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      lit_o <= 1'b0;
    end else begin
      lit_o <= run_i && (phase < duty_i) && (digit_o <= count_i);
    end
  end

endmodule
`default_nettype wire

// ---- logic/lsd_decoder.v ----
// Serial command decoder and mode controller of the four-digit LED driver.
`timescale 1ns/1ps
`include "lsd_defs.vh"
`default_nettype none

// The three serial pins are sampled by the system clock and never used as
// clocks, so the whole block stays in one clock domain. The price is a
// speed limit: each level of the serial clock must last longer than one
// system clock cycle, or an edge is lost in the synchroniser.
// Every display pin comes from a flip-flop, so the pins never glitch while
// the command logic and the scanner settle.

module lsd_decoder #(
  parameter SUBSLOT_CYCLES = `LSD_SUBSLOT_NS / `LSD_CLK_NS
) (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       serial_data_i,
  input  wire       serial_clk_i,
  input  wire       load_i,
  output reg        cascade_data_o,
  output reg  [7:0] segment_o,
  output reg  [3:0] digit_select_o,
  output reg        standby_o
);

  // ========================================================================
  // Display operating states.
  // Standby has a state of its own so its flag can be told apart from blank.
  localparam ST_BLANK  = 2'd0;
  localparam ST_NORMAL = 2'd1;
  localparam ST_ALLON  = 2'd2;
  localparam ST_STBY   = 2'd3;

  // Pin index in the synchroniser bus.
  localparam PIN_DATA = 0;
  localparam PIN_CLK  = 1;
  localparam PIN_LOAD = 2;

  // ========================================================================
  // Character decode for decode mode; bit 0 is segment a, bit 7 the point.
  // Codes 10..14 show minus, E, H, L, P and code 15 is blank.
  function [6:0] char_segments;
    input [3:0] code;
    begin
      case (code)
        4'h0:    char_segments = 7'h3f;
        4'h1:    char_segments = 7'h06;
        4'h2:    char_segments = 7'h5b;
        4'h3:    char_segments = 7'h4f;
        4'h4:    char_segments = 7'h66;
        4'h5:    char_segments = 7'h6d;
        4'h6:    char_segments = 7'h7d;
        4'h7:    char_segments = 7'h07;
        4'h8:    char_segments = 7'h7f;
        4'h9:    char_segments = 7'h6f;
        4'ha:    char_segments = 7'h40;
        4'hb:    char_segments = 7'h79;
        4'hc:    char_segments = 7'h76;
        4'hd:    char_segments = 7'h38;
        4'he:    char_segments = 7'h73;
        default: char_segments = 7'h00;
      endcase
    end
  endfunction

  // One-hot digit select from a digit index.
  function [3:0] digit_onehot;
    input [1:0] idx;
    begin
      digit_onehot = 4'h1 << idx;
    end
  endfunction

  // True for the selectors that address one of the four display data bytes.
  function is_data_sel;
    input [3:0] sel;
    begin
      is_data_sel = (sel >= `LSD_SEL_DATA0) && (sel <= `LSD_SEL_DATA3);
    end
  endfunction

  // Data register index addressed by a data selector; selector 2 is digit 0.
  function [1:0] data_index;
    input [3:0] sel;
    begin
      data_index = sel[1:0] - 2'h2;
    end
  endfunction

  // ========================================================================
  // Pin synchronisers; the serial clock is sampled, not used as a clock.
  // Reset clears every stage to the idle low level of the pins, so no false
  // edge is seen when reset lets go.
  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;

  lsd_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   ({load_i, serial_clk_i, serial_data_i}),
    .level_o (pin_level),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  wire sdata     = pin_level[PIN_DATA];
  wire sclk_rise = pin_rise[PIN_CLK];
  wire load_rise = pin_rise[PIN_LOAD];
  wire load_fall = pin_fall[PIN_LOAD];

  // ========================================================================
  // Sixteen-bit shift register, most significant bit first.
  reg [15:0] shift;

  // Data and clock pass equal synchroniser depth, so they stay aligned.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      shift <= 16'h0000;
    end else if (sclk_rise) begin
      shift <= {shift[14:0], sdata};
    end
  end

  // The bit leaving the top is passed on to a cascaded device.
  // It follows the top bit one cycle late; a downstream device sees it through
  // its own synchroniser, which the slow serial clock leaves ample time for.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cascade_data_o <= 1'b0;
    end else begin
      cascade_data_o <= shift[15];
    end
  end

  // ========================================================================
  // Two-phase load capture: mode and selector on the rise, setting on fall.
  reg [3:0] cmd_mode;
  reg [3:0] cmd_sel;
  reg [7:0] cmd_value;
  reg       cmd_armed;
  reg       cmd_go;

  // A fall without a preceding rise is ignored, which keeps a lone setting
  // byte from acting on a stale mode; the host must still pair the two.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cmd_mode  <= `LSD_MODE_BLANK;
      cmd_sel   <= 4'h0;
      cmd_value <= 8'h00;
      cmd_armed <= 1'b0;
      cmd_go    <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      if (load_rise) begin
        cmd_mode  <= shift[`LSD_MODE_HI:`LSD_MODE_LO];
        cmd_sel   <= shift[`LSD_SEL_HI:`LSD_SEL_LO];
        cmd_armed <= 1'b1;
      end else if (load_fall && cmd_armed) begin
        cmd_value <= shift[7:0];
        cmd_armed <= 1'b0;
        cmd_go    <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Mode state machine.
  reg [1:0] state;
  reg [1:0] next_state;
  // A standby word with a zero low nibble is a data clear; any other nibble
  // enters standby with every setting kept.
  wire      do_clear = cmd_go && (cmd_mode == `LSD_MODE_STBY) &&
                       (cmd_value[3:0] == `LSD_STBY_CLEAR);

  // Load commands leave the state alone so normal display keeps running.
  // Codes 5 to 15 are undefined and fall to the default arm unchanged.
  always @* begin
    next_state = state;
    if (cmd_go) begin
      case (cmd_mode)
        `LSD_MODE_BLANK:  next_state = ST_BLANK;
        `LSD_MODE_NORMAL: next_state = ST_NORMAL;
        `LSD_MODE_ALLON:  next_state = ST_ALLON;
        `LSD_MODE_STBY:   next_state = do_clear ? ST_BLANK : ST_STBY;
        default:          next_state = state;
      endcase
    end
  end

  // Power-up lands in blank, so nothing lights until normal or all-on is commanded.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ST_BLANK;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Setting registers.
  reg [3:0] digit_duty_level;
  reg [3:0] decode_mode;
  reg [1:0] digit_count;
  reg [7:0] pattern [0:3];
  wire      do_load = cmd_go && (cmd_mode == `LSD_MODE_LOAD);
  integer   i;

  // Clear and reset share defaults; blank, all-on and standby touch nothing.
  always @(posedge clk_i) begin
    if (!rst_b_i || do_clear) begin
      digit_duty_level <= `LSD_DUTY_RST;
      decode_mode      <= `LSD_DECODE_RST;
      digit_count      <= `LSD_COUNT_RST;
      for (i = 0; i < 4; i = i + 1) begin
        pattern[i] <= `LSD_DATA_RST;
      end
    end else if (do_load) begin
      if (cmd_sel == `LSD_SEL_DUTY) begin
        digit_duty_level <= cmd_value[3:0];
      end else if (cmd_sel == `LSD_SEL_DECDIG) begin
        decode_mode <= cmd_value[7:4];
        digit_count <= cmd_value[1:0];
      end else if (is_data_sel(cmd_sel)) begin
        pattern[data_index(cmd_sel)] <= cmd_value;
      end
      // Any other selector falls through every arm and changes nothing.
    end
  end

  // ========================================================================
  // Digit scanner; it runs while the display is lit.
  // All-on runs it too, so the forced segments still share time between the
  // digits and keep to the duty setting.
  wire       scan_run = (state == ST_NORMAL) || (state == ST_ALLON);
  wire [1:0] scan_digit;
  wire       scan_lit;

  lsd_scan #(
    .SUBSLOT_CYCLES (SUBSLOT_CYCLES)
  ) u_scan (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (scan_run),
    .count_i (digit_count),
    .duty_i  (digit_duty_level),
    .digit_o (scan_digit),
    .lit_o   (scan_lit)
  );

  // ========================================================================
  // Segment pattern of the digit now being scanned.
  reg [7:0] cur_pattern;
  reg [7:0] cur_segments;

  // Settings are read live, so a fresh load shows at the next refresh.
  // In raw mode the data byte maps straight to segments a to g and the point.
  always @* begin
    cur_pattern = pattern[scan_digit];
    if (decode_mode == 4'h0) begin
      cur_segments = cur_pattern;
    end else begin
      cur_segments = {cur_pattern[7], char_segments(cur_pattern[3:0])};
    end
  end

  // ========================================================================
  // Output drivers, all registered.
  // Blank and standby both drive the pins dark; only the flag tells them apart.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      segment_o      <= 8'h00;
      digit_select_o <= 4'h0;
      standby_o      <= 1'b0;
    end else begin
      standby_o <= (state == ST_STBY);
      case (state)
        ST_NORMAL: begin
          segment_o      <= scan_lit ? cur_segments : 8'h00;
          digit_select_o <= scan_lit ? digit_onehot(scan_digit) : 4'h0;
        end
        ST_ALLON: begin
          segment_o      <= 8'hff;
          digit_select_o <= scan_lit ? digit_onehot(scan_digit) : 4'h0;
        end
        ST_STBY: begin
          // Standby keeps every setting but lights nothing.
          segment_o      <= 8'h00;
          digit_select_o <= 4'h0;
        end
        default: begin
          segment_o      <= 8'h00;
          digit_select_o <= 4'h0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- verification/lsd_decoder_monitor.sv ----
// Concurrent checks on the pins of the serial command decoder.
`timescale 1ns/1ps
`default_nettype none

module lsd_decoder_monitor #(
  parameter SUBSLOT_CYCLES = 64
) (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       serial_data_i,
  input wire logic       serial_clk_i,
  input wire logic       load_i,
  input wire logic       cascade_data_o,
  input wire logic [7:0] segment_o,
  input wire logic [3:0] digit_select_o,
  input wire logic       standby_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================================
  // Helpers: pin histories and a run counter of lit digit cycles.
  // The histories are short on purpose, so a late answer shows as a failure.
  logic [7:0]  sck_hist;
  logic [7:0]  load_hist;
  logic        seen_load;
  logic [15:0] lit_run;
  always_ff @(posedge clk_i) begin
    sck_hist  <= {sck_hist[6:0], serial_clk_i};
    load_hist <= {load_hist[6:0], load_i};
    if (!rst_b_i) begin
      seen_load <= 1'b0;
      lit_run   <= 16'h0000;
    end else begin
      seen_load <= seen_load | load_i;
      lit_run   <= (digit_select_o != 4'h0) ? lit_run + 16'h0001 : 16'h0000;
    end
  end

  // ==========================================================================
  // Assertions.
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |=>
    segment_o == 8'h00 && digit_select_o == 4'h0 && !standby_o && !cascade_data_o)
    else $error("outputs not quiet after reset");
  a_digit_onehot: assert property ($onehot0(digit_select_o))
    else $error("more than one digit driven");
  a_dark_until_load: assert property (!seen_load |->
    digit_select_o == 4'h0 && segment_o == 8'h00)
    else $error("display lit before any command");
  a_standby_dark: assert property (standby_o |->
    digit_select_o == 4'h0 && segment_o == 8'h00)
    else $error("display lit in standby");
  a_cascade_cause: assert property ($changed(cascade_data_o) |->
    |(sck_hist[6:0] & ~sck_hist[7:1]))
    else $error("cascade bit moved without a serial clock rise");
  a_standby_cause: assert property ($rose(standby_o) |->
    |(~load_hist[6:0] & load_hist[7:1]))
    else $error("standby entered without a load fall");
  a_lit_run_bound: assert property (lit_run <= 15 * SUBSLOT_CYCLES)
    else $error("digit lit longer than fifteen sixteenths");
  a_no_digit_jump: assert property (digit_select_o != 4'h0 &&
    $past(digit_select_o) != 4'h0 |-> digit_select_o == $past(digit_select_o))
    else $error("digits switched without a dark gap");

  // Main scenarios seen.
  c_standby: cover property ($rose(standby_o));
  c_all_on: cover property (segment_o == 8'hff && digit_select_o != 4'h0);
  c_last_digit: cover property (digit_select_o == 4'h8);
endmodule

bind lsd_decoder lsd_decoder_monitor #(.SUBSLOT_CYCLES(SUBSLOT_CYCLES)) u_lsd_decoder_monitor (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .serial_data_i(serial_data_i),
  .serial_clk_i(serial_clk_i), .load_i(load_i), .cascade_data_o(cascade_data_o),
  .segment_o(segment_o), .digit_select_o(digit_select_o), .standby_o(standby_o));
`default_nettype wire

// ---- verification/lsd_host.sv ----
// Host model that shifts command words into the decoder over three wires.
`timescale 1ns/1ps
`default_nettype none

module lsd_host (
  input  wire logic clk_i,
  output var logic  serial_data_o,
  output var logic  serial_clk_o,
  output var logic  load_o
);
  // The serial clock stands low between frames; it never runs free.
  initial begin
    serial_data_o = 1'b0;
    serial_clk_o  = 1'b0;
    load_o        = 1'b0;
  end

  // Half a serial clock period, 80 ns at the system clock.
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask

  // ==========================================================================
  // One whole word, MSB first, with the strobe low until all sixteen bits are in.
  task automatic send(input logic [15:0] word);
    for (int i = 15; i >= 0; i--) begin
      serial_data_o <= word[i];
      half();
      serial_clk_o <= 1'b1;
      half();
      serial_clk_o <= 1'b0;
    end
    // The data line is driven to the inverse of the last bit before the strobe.
    serial_data_o <= ~word[0];
    half();
    load_o <= 1'b1;
    half();
    load_o <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the serial command decoder against a display model.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int SUB = 4;
  logic       clk_i   = 1'b0;
  logic       rst_b_i = 1'b0;
  wire        sdata;
  wire        sclk;
  wire        load;
  logic       cascade;
  logic [7:0] seg;
  logic [3:0] dig;
  logic       stby;
  int         miscompares  = 0;
  int         total_checks = 0;
  int         cycles       = 0;
  int         st;
  int         duty_m;
  int         dec_m;
  int         cnt_m;
  int         data_m [4];

  always #10 clk_i = ~clk_i;

  lsd_host u_lsd_host (.clk_i(clk_i), .serial_data_o(sdata), .serial_clk_o(sclk),
    .load_o(load));
  lsd_decoder #(.SUBSLOT_CYCLES(SUB)) u_lsd_decoder (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .serial_data_i(sdata), .serial_clk_i(sclk), .load_i(load), .cascade_data_o(cascade),
    .segment_o(seg), .digit_select_o(dig), .standby_o(stby));

  // ==========================================================================
  // Reporting.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // A hang is cut short well above the roughly 12400 cycles the run needs.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Behavioural model: state 0 blank, 1 normal, 3 all on, 4 standby.
  task automatic model_clear();
    st     = 0;
    duty_m = 15;
    dec_m  = 1;
    cnt_m  = 3;
    data_m = '{0, 0, 0, 0};
  endtask

  task automatic apply(input logic [15:0] w);
    case (w[15:12])
      4'h0: st = 0;
      4'h1: st = 1;
      4'h3: st = 3;
      4'h4: if (w[3:0] == 4'h0) model_clear(); else st = 4;
      4'h2: case (w[11:8])
        4'h0: duty_m = w[3:0];
        4'h1: begin
          dec_m = (w[7:4] != 4'h0);
          cnt_m = w[1:0];
        end
        4'h2, 4'h3, 4'h4, 4'h5: data_m[w[11:8] - 4'h2] = w[7:0];
        default: ;
      endcase
      default: ;
    endcase
  endtask

  // Under decode only zero data is used, which keeps the character table out.
  function automatic logic [7:0] exp_seg(input int k);
    if (st == 3) return 8'hff;
    if (dec_m != 0) return 8'h3f;
    return data_m[k][7:0];
  endfunction

  // One full scan period: each enabled digit is lit duty sixteenths of its slot.
  task automatic measure();
    int lit [4];
    int bad;
    lit = '{0, 0, 0, 0};
    bad = 0;
    repeat ((cnt_m + 1) * 16 * SUB) begin
      @(negedge clk_i);
      for (int k = 0; k < 4; k++) begin
        if (dig[k]) begin
          lit[k]++;
          if (seg !== exp_seg(k)) bad++;
        end
      end
      if (st != 1 && st != 3 && (seg !== 8'h00 || dig !== 4'h0)) bad++;
    end
    for (int k = 0; k < 4; k++) begin
      check(lit[k], ((st == 1 || st == 3) && k <= cnt_m) ? duty_m * SUB : 0, "lit");
    end
    check(bad, 0, "segment pattern");
    check({31'h0, stby}, {31'h0, st == 4}, "standby flag");
  endtask

  task automatic cmd(input logic [15:0] w);
    u_lsd_host.send(w);
    apply(w);
    // A full slot more lets a digit left above a lowered count wrap back first.
    repeat (40 + 16 * SUB) @(posedge clk_i);
    measure();
    check({31'h0, cascade}, {31'h0, w[15]}, "cascade bit");
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(45));
    model_clear();
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    measure();
    cmd(16'h1000);
    cmd(16'h2103);
    for (int k = 0; k < 4; k++) cmd({4'h2, 4'(k + 2), 8'($urandom)});
    for (int k = 0; k < 16; k += 5) cmd({8'h20, 4'($urandom), 4'(k)});
    for (int k = 0; k < 4; k++) cmd({8'h21, 4'h0, 4'(k)});
    cmd({4'h3, 12'($urandom)});
    cmd({4'h0, 12'($urandom)});
    cmd(16'h1000);
    cmd({12'h400, 4'($urandom % 15 + 1)});
    cmd(16'h1000);
    cmd(16'h4000);
    cmd(16'h1000);
    for (int k = 0; k < 4; k++) cmd({4'($urandom % 11 + 5), 12'($urandom)});
    tally_and_finish();
  end
endmodule
`default_nettype wire
